// ### hw/drgl_consts.svh
`ifndef DRGL_CONSTS_SVH
`define DRGL_CONSTS_SVH
// ==========================================
// Clock
`define DRGL_CLK_HZ 125000000
// ==========================================
// Timing figures in their own units
`define DRGL_POR_MIN_MS 11
`define DRGL_POR_MAX_MS 60
`define DRGL_READY_S 30
`define DRGL_COLD_S 6
`define DRGL_WARM_MS 200
`define DRGL_ARM_MS 1
`define DRGL_SEEK_MS 10
// Derived cycle counts (least times round up)
`define DRGL_POR_CYC ((64'd11 * 64'd125000000 + 64'd999) / 64'd1000)
`define DRGL_READY_CYC (64'd30 * 64'd125000000)
`define DRGL_COLD_CYC (64'd6 * 64'd125000000)
`define DRGL_WARM_CYC ((64'd200 * 64'd125000000) / 64'd1000)
`define DRGL_ARM_CYC ((64'd1 * 64'd125000000 + 64'd999) / 64'd1000)
`define DRGL_SEEK_CYC ((64'd10 * 64'd125000000) / 64'd1000)
// 12 MHz tick from 125 MHz by accumulator
`define DRGL_ARB_INC 8'h0C
`define DRGL_ARB_MOD 8'h7D
// ==========================================
// Register byte addresses (window C0..DF)
`define DRGL_SEL_TOP 3'h6
`define DRGL_CTRL_ADDR 8'hC0
`define DRGL_STAT_ADDR 8'hC4
`define DRGL_PLUG_ADDR 8'hC8
`define DRGL_TOHOST_ADDR 8'hCC
`define DRGL_FROMHOST_ADDR 8'hD0
`define DRGL_BUSCTL_ADDR 8'hD4
`define DRGL_ARBT_ADDR 8'hD8
// Control fields
`define DRGL_C_SPIN 0
`define DRGL_C_START 1
`define DRGL_C_UNBLOCK 2
`define DRGL_C_SAMPLE 3
`define DRGL_C_WRBUSY 4
`define DRGL_C_INIT 5
`define DRGL_C_DMAGO 6
`define DRGL_C_DMADIR 7
`define DRGL_C_PERRCLR 8
// Reset values
`define DRGL_CTRL_RST 8'h01
`define DRGL_ARBT_RST 8'h1A
// Filter idle levels: acknowledge and host reset high
`define DRGL_PINS_RST 11'h006
`endif

// ### hw/drgl_pkg.sv
package drgl_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    S_POR = 3'h0,
    S_RECAL = 3'h1,
    S_SPINWAIT = 3'h2,
    S_SPINUP = 3'h3,
    S_READY = 3'h4,
    S_WARM_WR = 3'h5,
    S_WARM_SYNC = 3'h6
  } drgl_state_t;
  // Pins from outside, all passed through the three-stage filter
  typedef struct packed {
    logic seek_fault;
    logic [2:0] id_plugs;
    logic parity_check_plug;
    logic reset_kind_plug;
    logic self_seek_plug;
    logic spin_wait_plug;
    logic dma_ack_n;
    logic host_rst_n;
    logic supply_ok;
  } drgl_pins_t;
endpackage : drgl_pkg

// ### hw/drgl_glue.sv
`timescale 1ns/1ps
`include "drgl_consts.svh"
//
// Contract
// - Spin-wait plug: hold spindle until start command
// - No spin-wait plug: auto spin, ready in 30s
// - Self-seek plug: endless seek, stop on fault
// - Host reset: cold if plug fitted, else warm
// - Cold reset clears all, resamples plugs, bus free; arbitration timing, block latch, parity error, to-host/from-host bytes keep; start flag kept on host reset
// - No commands accepted during six-second cold reset; code refuses only start and DMA commands, other control writes still act
// - Warm reset finishes sector, resyncs, about 200ms
// - Cold reset on low supply or cold host reset
// - Power-on clear resets units, arms spring, brakes
// - Clear held 11-60ms after supplies good, recal
// - Host reset drives reset-sense low, selects path
// - Block latch forces message/control/io deasserted
// - Spindle off on clear or spin enable low
// - Controller selected only for addresses C0-DF
// - Sample id and option plugs on command
// - Address then strobed data over processor bus
// - Registers set role, bus lines, arbitration timing
// - Direction high: buffer byte into to-host register
// - Direction low: drive from-host byte, enable low
// - Each DMA byte uses request and acknowledge
// - Arbitration timing from 12 MHz tick
// - Id plugs weigh four, two, one
// - Parity plug fitted enables odd parity check
module drgl_glue #(
  parameter logic [31:0] POR_CYC = 32'(`DRGL_POR_CYC),
  parameter logic [31:0] READY_CYC = 32'(`DRGL_READY_CYC),
  parameter logic [31:0] COLD_CYC = 32'(`DRGL_COLD_CYC),
  parameter logic [31:0] WARM_CYC = 32'(`DRGL_WARM_CYC),
  parameter logic [31:0] SEEK_CYC = 32'(`DRGL_SEEK_CYC),
  parameter logic [31:0] ARM_CYC = 32'(`DRGL_ARM_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire drgl_pkg::drgl_pins_t pins,
  input wire logic [7:0] buffer_data_bus_in,
  output logic [7:0] buffer_data_bus_out,
  output logic dma_output_enable_n,
  output logic dma_dir,
  output logic dma_req_n,
  output logic por_clear_n,
  output logic motor_on,
  output logic motor_brake,
  output logic spring_arm,
  output logic reset_sense_pin_n,
  output logic bus_line_block_latch,
  output logic [7:0] bus_ctl_out,
  output logic initiator_mode,
  output logic arb_tick,
  output logic drive_ready,
  output logic seek_dir
);
  // ==========================================
  // Input filter: three flops, change taken when 2nd and 3rd agree
  localparam int NP = $bits(drgl_pkg::drgl_pins_t);
  logic [NP-1:0] s1_reg, s2_reg, s3_reg, flt_reg;
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      // One filter per pin, cleared to the pin's idle level
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg[gi] <= 1'(`DRGL_PINS_RST >> gi);
          s2_reg[gi] <= 1'(`DRGL_PINS_RST >> gi);
          s3_reg[gi] <= 1'(`DRGL_PINS_RST >> gi);
          flt_reg[gi] <= 1'(`DRGL_PINS_RST >> gi);
        end else begin
          s1_reg[gi] <= pins[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi]) flt_reg[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate
  drgl_pkg::drgl_pins_t fp;
  assign fp = drgl_pkg::drgl_pins_t'(flt_reg);
  // ==========================================
  // Reset event decode
  logic host_rst_d_reg;
  wire host_rst = ~fp.host_rst_n;
  wire host_rst_rise = host_rst & ~host_rst_d_reg;
  // Cold path: low supply or host reset with the plug fitted
  wire cold_req = ~fp.supply_ok | (host_rst & fp.reset_kind_plug);
  // Warm path only when the plug is absent
  wire warm_req = host_rst_rise & ~fp.reset_kind_plug;
  // ==========================================
  // APB decode
  wire in_window = paddr[7:5] == `DRGL_SEL_TOP;
  wire setup = psel & ~penable;
  wire a_ctrl = paddr == `DRGL_CTRL_ADDR;
  wire a_stat = paddr == `DRGL_STAT_ADDR;
  wire a_plug = paddr == `DRGL_PLUG_ADDR;
  wire a_toh = paddr == `DRGL_TOHOST_ADDR;
  wire a_frh = paddr == `DRGL_FROMHOST_ADDR;
  wire a_bctl = paddr == `DRGL_BUSCTL_ADDR;
  wire a_arbt = paddr == `DRGL_ARBT_ADDR;
  wire mapped = in_window & (a_ctrl | a_stat | a_plug | a_toh | a_frh |
                a_bctl | a_arbt);
  wire wr_acc = psel & penable & pready & pwrite & mapped;
  // ==========================================
  // State
  drgl_pkg::drgl_state_t st_reg, st_next;
  logic [31:0] cnt_reg;
  logic [31:0] arm_cnt_reg;
  logic [31:0] seek_cnt_reg;
  logic [8:0] ctrl_reg;
  logic [7:0] arbt_reg;
  logic [7:0] plug_reg;
  logic spin_wait_reg;
  logic started_reg;
  logic perr_reg;
  logic [7:0] toh_reg;
  logic [8:0] frh_reg;
  logic dma_busy_reg;
  logic ack_d_reg;
  logic [7:0] arb_acc_reg;
  // Start and DMA commands refused while cold reset and recalibration run
  wire busy = st_reg == drgl_pkg::S_POR || st_reg == drgl_pkg::S_RECAL;
  wire wr_ctrl = wr_acc & a_ctrl;
  wire start_cmd = wr_ctrl & pwdata[`DRGL_C_START] & ~busy;
  wire cnt_done = cnt_reg == 32'h0;
  wire ack_rise = ~fp.dma_ack_n & ack_d_reg;
  // ==========================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      // Hold clear until supplies good for the delay
      drgl_pkg::S_POR:
        if (!cold_req && cnt_done) st_next = drgl_pkg::S_RECAL;
      // Full recalibration after release
      drgl_pkg::S_RECAL: begin
        if (cnt_done && spin_wait_reg && !started_reg)
          st_next = drgl_pkg::S_SPINWAIT;
        else if (cnt_done) st_next = drgl_pkg::S_SPINUP;
      end
      // Spindle held until a start command
      drgl_pkg::S_SPINWAIT: if (start_cmd) st_next = drgl_pkg::S_SPINUP;
      drgl_pkg::S_SPINUP: if (cnt_done) st_next = drgl_pkg::S_READY;
      drgl_pkg::S_READY: st_next = drgl_pkg::S_READY;
      // Let the sector write finish
      drgl_pkg::S_WARM_WR:
        if (!ctrl_reg[`DRGL_C_WRBUSY]) st_next = drgl_pkg::S_WARM_SYNC;
      // Partial servo resync then bus free
      drgl_pkg::S_WARM_SYNC: if (cnt_done) st_next = drgl_pkg::S_READY;
      default: st_next = drgl_pkg::S_POR;
    endcase
    // Cold reset overrides everything else; warm reset only when not busy
    if (cold_req) st_next = drgl_pkg::S_POR;
    else if (warm_req && !busy) st_next = drgl_pkg::S_WARM_WR;
  end
  // ==========================================
  // Counter loads on state entry
  logic [31:0] cnt_next;
  always_comb begin
    cnt_next = cnt_done ? 32'h0 : cnt_reg - 32'h1;
    if (st_next != st_reg || cold_req) begin
      case (st_next)
        drgl_pkg::S_POR: cnt_next = POR_CYC;
        drgl_pkg::S_RECAL: cnt_next = COLD_CYC;
        drgl_pkg::S_SPINUP: cnt_next = READY_CYC;
        drgl_pkg::S_WARM_SYNC: cnt_next = WARM_CYC;
        default: cnt_next = 32'h0;
      endcase
    end
  end
  // State and counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= drgl_pkg::S_POR;
      cnt_reg <= 32'h0;
      host_rst_d_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      host_rst_d_reg <= host_rst;
    end
  end
  // ==========================================
  // Plug capture; spin-wait caught only at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      plug_reg <= 8'h00;
      spin_wait_reg <= 1'b0;
      started_reg <= 1'b0;
    end else begin
      if (!fp.supply_ok) spin_wait_reg <= fp.spin_wait_plug;
      if (!fp.supply_ok) started_reg <= 1'b0;
      else if (start_cmd) started_reg <= 1'b1;
      // Id weights four-two-one sit in bits 2:0
      if (st_reg == drgl_pkg::S_POR ||
          (wr_ctrl && pwdata[`DRGL_C_SAMPLE])) begin
        plug_reg <= {2'h0, fp.self_seek_plug, fp.reset_kind_plug,
                     fp.parity_check_plug, fp.id_plugs};
      end
    end
  end
  // ==========================================
  // Control, timing and bus-line registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= {1'b0, `DRGL_CTRL_RST};
      arbt_reg <= `DRGL_ARBT_RST;
      bus_ctl_out <= 8'h00;
      initiator_mode <= 1'b0;
    end else if (st_reg == drgl_pkg::S_POR) begin
      // Clear returns control, bus lines and initiator mode to defaults; arbitration timing keeps its value
      ctrl_reg <= {1'b0, `DRGL_CTRL_RST};
      bus_ctl_out <= 8'h00;
      initiator_mode <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_reg <= pwdata[8:0];
      if (wr_ctrl) initiator_mode <= pwdata[`DRGL_C_INIT];
      if (wr_acc && a_arbt) arbt_reg <= pwdata[7:0];
      if (wr_acc && a_bctl) bus_ctl_out <= pwdata[7:0];
      // Bus free at end of warm reset
      if (st_reg == drgl_pkg::S_WARM_SYNC) bus_ctl_out <= 8'h00;
    end
  end
  // ==========================================
  // Block latch: set by warm reset, cleared only by write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_line_block_latch <= 1'b0;
      reset_sense_pin_n <= 1'b1;
    end else begin
      reset_sense_pin_n <= ~host_rst;
      // Set wins over a clear in the same cycle
      if (warm_req) bus_line_block_latch <= 1'b1;
      else if (wr_ctrl && pwdata[`DRGL_C_UNBLOCK])
        bus_line_block_latch <= 1'b0;
    end
  end
  // ==========================================
  // Power, motor and spring outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_clear_n <= 1'b0;
      motor_on <= 1'b0;
      motor_brake <= 1'b1;
      spring_arm <= 1'b0;
      arm_cnt_reg <= 32'h0;
      drive_ready <= 1'b0;
    end else begin
      por_clear_n <= st_next != drgl_pkg::S_POR;
      // Off under clear or when spin enable drops
      motor_on <= st_next != drgl_pkg::S_POR &&
                  st_next != drgl_pkg::S_SPINWAIT &&
                  ctrl_reg[`DRGL_C_SPIN];
      motor_brake <= st_next == drgl_pkg::S_POR;
      // Spring armed after a delay inside clear
      if (st_reg != drgl_pkg::S_POR) arm_cnt_reg <= ARM_CYC;
      else if (arm_cnt_reg != 32'h0) arm_cnt_reg <= arm_cnt_reg - 32'h1;
      spring_arm <= st_reg == drgl_pkg::S_POR &&
                    arm_cnt_reg == 32'h0;
      drive_ready <= st_next == drgl_pkg::S_READY;
    end
  end
  // ==========================================
  // Self exercise: seek back and forth until a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seek_dir <= 1'b0;
      seek_cnt_reg <= 32'h0;
    end else if (st_reg == drgl_pkg::S_READY && plug_reg[5] &&
                 !fp.seek_fault) begin
      if (seek_cnt_reg == 32'h0) begin
        seek_cnt_reg <= SEEK_CYC;
        seek_dir <= ~seek_dir;
      end else begin
        seek_cnt_reg <= seek_cnt_reg - 32'h1;
      end
    end
  end
  // ==========================================
  // 12 MHz arbitration tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arb_acc_reg <= 8'h00;
      arb_tick <= 1'b0;
    end else if (arb_acc_reg + `DRGL_ARB_INC >= `DRGL_ARB_MOD) begin
      arb_acc_reg <= arb_acc_reg + `DRGL_ARB_INC - `DRGL_ARB_MOD;
      arb_tick <= 1'b1;
    end else begin
      arb_acc_reg <= arb_acc_reg + `DRGL_ARB_INC;
      arb_tick <= 1'b0;
    end
  end
  // ==========================================
  // DMA handshake with the buffer sequencer
  wire dma_go = wr_ctrl & pwdata[`DRGL_C_DMAGO] & ~busy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_busy_reg <= 1'b0;
      dma_req_n <= 1'b1;
      dma_dir <= 1'b0;
      dma_output_enable_n <= 1'b1;
      buffer_data_bus_out <= 8'h00;
      toh_reg <= 8'h00;
      frh_reg <= 9'h000;
      perr_reg <= 1'b0;
      ack_d_reg <= 1'b1;
    end else begin
      ack_d_reg <= fp.dma_ack_n;
      if (st_reg == drgl_pkg::S_POR) begin
        dma_busy_reg <= 1'b0;
        dma_req_n <= 1'b1;
      end else if (dma_go) begin
        dma_busy_reg <= 1'b1;
        dma_req_n <= 1'b0;
        dma_dir <= pwdata[`DRGL_C_DMADIR];
      end else if (dma_busy_reg && ack_rise) begin
        dma_busy_reg <= 1'b0;
        dma_req_n <= 1'b1;
        if (dma_dir) toh_reg <= buffer_data_bus_in;
      end
      // Inbound byte driven while acknowledged
      dma_output_enable_n <= ~(dma_busy_reg & ~dma_dir &
                              ~fp.dma_ack_n);
      buffer_data_bus_out <= frh_reg[7:0];
      if (wr_acc && a_frh) begin
        frh_reg <= pwdata[8:0];
        // Odd parity expected when the plug is fitted
        if (plug_reg[3] && !(^pwdata[8:0])) perr_reg <= 1'b1;
      end else if (wr_ctrl && pwdata[`DRGL_C_PERRCLR]) begin
        perr_reg <= 1'b0;
      end
    end
  end
  // ==========================================
  // Read mux
  wire [31:0] stat_word = {20'h0, dma_busy_reg, perr_reg,
    bus_line_block_latch, started_reg, spin_wait_reg, busy,
    drive_ready, 2'h0, st_reg};
  wire [31:0] rd_mux = a_ctrl ? {23'h0, ctrl_reg} :
                       a_stat ? stat_word :
                       a_plug ? {24'h0, plug_reg} :
                       a_toh ? {24'h0, toh_reg} :
                       a_frh ? {23'h0, frh_reg} :
                       a_bctl ? {24'h0, bus_ctl_out} :
                       a_arbt ? {24'h0, arbt_reg} : 32'h0;
  // APB answer: ready in the access cycle, error on unmapped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup && !pwrite && mapped) ? rd_mux : 32'h0;
    end
  end
endmodule : drgl_glue

// ### tb/drgl_glue_properties.sv
`timescale 1ns/1ps
// ==========
// Port checks for the reset and bus glue
module drgl_glue_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire drgl_pkg::drgl_pins_t pins,
  input wire logic dma_output_enable_n,
  input wire logic dma_dir,
  input wire logic dma_req_n,
  input wire logic por_clear_n,
  input wire logic motor_on,
  input wire logic motor_brake,
  input wire logic reset_sense_pin_n,
  input wire logic bus_line_block_latch,
  input wire logic arb_tick,
  input wire logic drive_ready
);
  // One clock domain
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Bus answers
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no answer one cycle after setup");
  a_unmapped_err: assert property (psel && !penable && paddr[7:5] != 3'h6
    |=> pready && pslverr)
    else $error("address outside window not refused");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access cycle");
  // ==========
  // Clear and spindle
  a_clear_brakes: assert property (!por_clear_n [*2]
    |-> motor_brake && !motor_on)
    else $error("spindle not braked in clear");
  a_no_ready_clear: assert property (!por_clear_n [*2] |-> !drive_ready)
    else $error("ready during clear");
  // ==========
  // Buffer transfers and arbitration tick
  a_oe_dir: assert property (!dma_output_enable_n |-> !dma_dir)
    else $error("driving buffer bus in wrong direction");
  a_ack_ends_req: assert property ($rose(dma_req_n) && por_clear_n
    && $past(por_clear_n) |-> $past(pins.dma_ack_n, 2) == 1'b0)
    else $error("request ended without acknowledge");
  a_tick_gap: assert property (arb_tick |=> !arb_tick [*8])
    else $error("arbitration ticks too close");
  // ==========
  // Host reset paths
  a_sense_on_rst: assert property ($fell(pins.host_rst_n)
    |-> ##[1:8] !reset_sense_pin_n)
    else $error("reset sense not driven low");
  a_block_on_warm: assert property ($fell(reset_sense_pin_n)
    && !pins.reset_kind_plug |-> ##[0:3] bus_line_block_latch)
    else $error("block latch not set on warm reset");
  a_block_hold: assert property (bus_line_block_latch && !(psel && penable
    && pwrite && paddr == 8'hC0 && pwdata[2]) |=> bus_line_block_latch)
    else $error("block latch cleared without write");
endmodule : drgl_glue_properties

bind drgl_glue drgl_glue_properties drgl_glue_properties_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .pins, .dma_output_enable_n, .dma_dir, .dma_req_n, .por_clear_n,
  .motor_on, .motor_brake, .reset_sense_pin_n, .bus_line_block_latch,
  .arb_tick, .drive_ready);

// ### tb/drgl_seq_model.sv
`timescale 1ns/1ps
// ==========
// Buffer sequencer side of the byte handshake
module drgl_seq_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic dma_req_n,
  input wire logic dma_dir,
  input wire logic slow,
  input wire logic [7:0] next_byte,
  output logic dma_ack_n,
  output logic [7:0] buffer_data_bus
);
  logic [3:0] wait_reg; // Cycles waited on this request
  // Acknowledge after a short or long wait, hold until request drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_ack_n <= 1'b1;
      wait_reg <= 4'h0;
    end else if (dma_req_n) begin
      dma_ack_n <= 1'b1;
      wait_reg <= 4'h0;
    end else if (wait_reg == (slow ? 4'h6 : 4'h1)) begin
      dma_ack_n <= 1'b0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
  // Byte only while acknowledging a buffer read, else churn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_data_bus <= 8'h5A;
    end else if (!dma_ack_n && dma_dir) begin
      buffer_data_bus <= next_byte;
    end else begin
      buffer_data_bus <= ~buffer_data_bus;
    end
  end
endmodule : drgl_seq_model

// ### tb/drgl_glue_tb.sv
`timescale 1ns/1ps
module drgl_glue_tb;
  localparam int POR = 20;
  localparam int COLD = 30;
  localparam int READY = 40;
  localparam int WARM = 10;
  // ==========
  // Stimulus and observed signals
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, supply_ok = 1'b0, host_rst_n = 1'b1, slow = 1'b0;
  logic par = 1'b1, rk = 1'b0, ss = 1'b0, sw = 1'b0, seek_fault = 1'b0;
  logic [2:0] id = 3'h5;
  logic [7:0] paddr = 8'h00, next_byte = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, dma_ack_n, dma_output_enable_n, dma_dir;
  logic dma_req_n, por_clear_n, motor_on, motor_brake, spring_arm;
  logic reset_sense_pin_n, bus_line_block_latch, initiator_mode, arb_tick;
  logic drive_ready, seek_dir;
  logic [7:0] buffer_data_bus_in, buffer_data_bus_out, bus_ctl_out;
  drgl_pkg::drgl_pins_t pins;
  int num_errors = 0, n_compared = 0, k;
  assign pins = {seek_fault, id, par, rk, ss, sw, dma_ack_n, host_rst_n,
    supply_ok};
  // Clock at 125 MHz
  always #4 pclk = ~pclk;
  drgl_glue #(.POR_CYC(32'd20), .COLD_CYC(32'd30), .READY_CYC(32'd40),
    .WARM_CYC(32'd10), .SEEK_CYC(32'd5), .ARM_CYC(32'd3)) drgl_glue_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pins, .buffer_data_bus_in, .buffer_data_bus_out,
    .dma_output_enable_n, .dma_dir, .dma_req_n, .por_clear_n, .motor_on,
    .motor_brake, .spring_arm, .reset_sense_pin_n, .bus_line_block_latch,
    .bus_ctl_out, .initiator_mode, .arb_tick, .drive_ready, .seek_dir);
  drgl_seq_model drgl_seq_model_i (.pclk, .presetn, .dma_req_n, .dma_dir,
    .slow, .next_byte, .dma_ack_n, .buffer_data_bus(buffer_data_bus_in));
  // ==========
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic summarize();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  // ==========
  // Scenarios
  task automatic t_power_up();
    check(motor_brake, 1'b1);
    supply_ok <= 1'b1;
    for (k = 0; k < 200 && por_clear_n !== 1'b1; k++) tick(1);
    check(k >= POR && k <= POR + 10, 1'b1);
    for (k = 0; k < 300 && drive_ready !== 1'b1; k++) tick(1);
    check(drive_ready, 1'b1);
    check(motor_on, 1'b1);
  endtask : t_power_up
  task automatic t_regs();
    apb(1'b0, 8'hD8, 32'h0);
    check(rdat, 32'h1A);
    apb(1'b1, 8'hC0, 32'h9);
    apb(1'b0, 8'hC8, 32'h0);
    check(rdat, 32'h0D);
    apb(1'b1, 8'hD0, 32'h0);
    apb(1'b0, 8'hC4, 32'h0);
    check(rdat[10], 1'b1);
    apb(1'b1, 8'hC0, 32'h101);
    apb(1'b0, 8'h10, 32'h0);
    check(rerr, 1'b1);
    check(rdat, 32'h0);
    apb(1'b1, 8'hDC, 32'h7);
    check(rerr, 1'b1);
  endtask : t_regs
  task automatic t_dma(input logic dir, input logic [7:0] b);
    slow <= dir;
    next_byte <= b;
    apb(1'b1, 8'hD0, {23'h0, ~^b, b});
    apb(1'b1, 8'hC0, {24'h0, dir, 7'h41});
    for (k = 0; k < 20 && dma_req_n !== 1'b0; k++) tick(1);
    if (!dir) begin
      for (k = 0; k < 20 && dma_output_enable_n !== 1'b0; k++) tick(1);
      check(dma_output_enable_n, 1'b0);
      check(buffer_data_bus_out, b);
    end
    for (k = 0; k < 40 && dma_req_n !== 1'b1; k++) tick(1);
    check(dma_req_n, 1'b1);
    apb(1'b0, 8'hCC, 32'h0);
    if (dir) check(rdat, {24'h0, b});
    apb(1'b0, 8'hC4, 32'h0);
    check(rdat[10], 1'b0);
  endtask : t_dma
  task automatic t_warm();
    apb(1'b1, 8'hD4, 32'h5A);
    apb(1'b1, 8'hC0, 32'h11);
    host_rst_n <= 1'b0;
    tick(8);
    check(reset_sense_pin_n, 1'b0);
    check(bus_line_block_latch, 1'b1);
    host_rst_n <= 1'b1;
    tick(WARM + 30);
    check({drive_ready, bus_ctl_out}, 9'h05A);
    apb(1'b1, 8'hC0, 32'h1);
    tick(WARM + 30);
    check(bus_line_block_latch, 1'b1);
    check({por_clear_n, drive_ready, bus_ctl_out}, 10'h300);
    apb(1'b1, 8'hC0, 32'h5);
    tick(2);
    check(bus_line_block_latch, 1'b0);
    apb(1'b1, 8'hC0, 32'h0);
    tick(4);
    check(motor_on, 1'b0);
  endtask : t_warm
  task automatic t_cold();
    rk <= 1'b1;
    tick(8);
    apb(1'b1, 8'hC0, 32'h9);
    id <= 3'h7;
    par <= 1'b0;
    host_rst_n <= 1'b0;
    for (k = 0; k < 12 && por_clear_n !== 1'b0; k++) tick(1);
    check(por_clear_n, 1'b0);
    apb(1'b1, 8'hD8, 32'h55);
    host_rst_n <= 1'b1;
    for (k = 0; k < 100 && por_clear_n !== 1'b1; k++) tick(1);
    check(por_clear_n, 1'b1);
    apb(1'b0, 8'hD8, 32'h0);
    check(rdat, 32'h1A);
    apb(1'b0, 8'hC8, 32'h0);
    check(rdat, 32'h17);
    apb(1'b1, 8'hD0, 32'h0);
    apb(1'b0, 8'hC4, 32'h0);
    check(rdat[10], 1'b0);
  endtask : t_cold
  task automatic t_spin_wait();
    supply_ok <= 1'b0;
    sw <= 1'b1;
    tick(8);
    check(por_clear_n, 1'b0);
    supply_ok <= 1'b1;
    tick(POR + COLD + READY + 40);
    check({por_clear_n, motor_on}, 2'b10);
    apb(1'b1, 8'hC0, 32'h3);
    for (k = 0; k < READY + 60 && drive_ready !== 1'b1; k++) tick(1);
    check(drive_ready, 1'b1);
  endtask : t_spin_wait
  task automatic t_seek();
    logic d;
    ss <= 1'b1;
    tick(8);
    apb(1'b1, 8'hC0, 32'h9);
    d = seek_dir;
    tick(6);
    check(seek_dir, !d);
    seek_fault <= 1'b1;
    tick(8);
    d = seek_dir;
    tick(12);
    check(seek_dir, d);
  endtask : t_seek
  // ==========
  // Main sequence
  initial begin
    tick(8);
    presetn <= 1'b1;
    tick(2);
    t_power_up();
    t_regs();
    t_dma(1'b1, 8'h3C);
    t_dma(1'b0, 8'hA5);
    t_warm();
    t_cold();
    t_spin_wait();
    t_seek();
    summarize();
  end
  // Watchdog against a hang
  initial begin
    tick(20000);
    num_errors++;
    summarize();
  end
endmodule : drgl_glue_tb
